// ==== hw/fcsp_pkg.sv ====
// package: register map, field positions, reset values and types of the flash command block
package fcsp_pkg;
  // register offsets (8-bit registers, byte addressed)
  localparam logic [3:0] FCSP_OFS_CMD_STATUS = 4'h6;
  localparam logic [3:0] FCSP_OFS_ERR_STATUS = 4'h7;
  localparam logic [3:0] FCSP_OFS_PARAM_INDEX = 4'h1;
  localparam logic [3:0] FCSP_OFS_PARAM_HI = 4'ha;
  localparam logic [3:0] FCSP_OFS_PARAM_LO = 4'hb;
  localparam logic [3:0] FCSP_OFS_PROTECT = 4'h8;
  localparam logic [3:0] FCSP_OFS_TAG_HI = 4'hc;
  localparam logic [3:0] FCSP_OFS_TAG_LO = 4'hd;
  localparam logic [3:0] FCSP_OFS_ECC_INDEX = 4'h4;
  localparam logic [3:0] FCSP_OFS_ECC_HI = 4'he;
  localparam logic [3:0] FCSP_OFS_ECC_LO = 4'hf;
  localparam logic [3:0] FCSP_OFS_ID = 4'h0;
  // command status bit positions
  localparam int FCSP_BIT_CCF = 7;
  localparam int FCSP_BIT_ACC = 5;
  localparam int FCSP_BIT_PV = 4;
  localparam int FCSP_BIT_BUSY = 3;
  localparam int FCSP_BIT_ST1 = 1;
  localparam int FCSP_BIT_ST0 = 0;
  // error status bit positions
  localparam int FCSP_BIT_DFD = 1;
  localparam int FCSP_BIT_SFD = 0;
  // protection register bit positions
  localparam int FCSP_BIT_OPEN = 7;
  localparam int FCSP_BIT_HDIS = 5;
  localparam int FCSP_BIT_HS = 3;
  localparam int FCSP_BIT_LDIS = 2;
  localparam int FCSP_BIT_LS = 0;
  // protected ranges (global addresses)
  localparam logic [22:0] FCSP_HIGH_END = 23'h7f_ffff;
  localparam logic [22:0] FCSP_HIGH_BASE_2K = 23'h7f_f800;
  localparam logic [22:0] FCSP_HIGH_BASE_4K = 23'h7f_f000;
  localparam logic [22:0] FCSP_HIGH_BASE_8K = 23'h7f_e000;
  localparam logic [22:0] FCSP_HIGH_BASE_16K = 23'h7f_c000;
  localparam logic [22:0] FCSP_LOW_BASE = 23'h7f_8000;
  localparam logic [22:0] FCSP_LOW_END_1K = 23'h7f_83ff;
  localparam logic [22:0] FCSP_LOW_END_2K = 23'h7f_87ff;
  localparam logic [22:0] FCSP_LOW_END_4K = 23'h7f_8fff;
  localparam logic [22:0] FCSP_LOW_END_8K = 23'h7f_9fff;
  localparam logic [22:0] FCSP_PROT_WORD_ADDR = 23'h7f_ff0c;
  // parameter indices
  localparam logic [2:0] FCSP_IX_CMD = 3'h0;
  localparam logic [2:0] FCSP_IX_ADDR = 3'h1;
  localparam logic [2:0] FCSP_IX_CNT = 3'h2;
  localparam logic [2:0] FCSP_IX_DATA1 = 3'h3;
  localparam logic [2:0] FCSP_IX_DATA2 = 3'h4;
  localparam logic [2:0] FCSP_IX_DATA3 = 3'h5;
  // command codes
  localparam logic [7:0] FCSP_CMD_ERASE_VERIFY_DF = 8'h10;
  localparam logic [7:0] FCSP_CMD_PROGRAM_PF = 8'h06;
  localparam logic [7:0] FCSP_CMD_ERASE_PF_SECTOR = 8'h0a;
  localparam logic [7:0] FCSP_CMD_FULL_PARTITION = 8'h0f;
  localparam logic [7:0] FCSP_CMD_PARTITION = 8'h20;
  localparam logic [7:0] FCSP_CMD_LOAD_DATA = 8'h0d;
  // partition limits, counted in 256 byte sectors
  localparam int FCSP_SECTOR_BYTES = 256;
  localparam logic [15:0] FCSP_DF_MAX_SECTORS = 16'h0080;
  localparam logic [15:0] FCSP_ER_MAX_SECTORS = 16'h0010;
  // reset values
  localparam logic [7:0] FCSP_RST_PROTECT = 8'hff;
  localparam logic [7:0] FCSP_ID_VALUE = 8'h5a; // arbitrary identity value
  // time to emulate one flash operation step
  localparam int FCSP_STEP_NS = 20;
  localparam int FCSP_CLK_NS = 5;
  localparam int FCSP_STEP_CYC = (FCSP_STEP_NS + FCSP_CLK_NS - 1) / FCSP_CLK_NS;

  typedef enum logic [4:0] {
    FCSP_IDLE = 5'b00001,
    FCSP_INIT = 5'b00010,
    FCSP_CHECK = 5'b00100,
    FCSP_RUN = 5'b01000,
    FCSP_EEE = 5'b10000
  } fcsp_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fcsp_bus_req_t;

  // flash array access port to the macro
  typedef struct packed {
    logic req;
    logic [22:0] addr;
    logic erase;
  } fcsp_arr_req_t;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
    logic sbe;
    logic dbe;
  } fcsp_arr_rsp_t;
endpackage : fcsp_pkg

// ==== hw/fcsp_ctrl.sv ====
// flash command launch, status, error, tag counter and protection decode
// Overview of operation
// - bit 7 completes; write one launches
// - access error on sequence or illegal command
// - access error blocks launch
// - access error clears only by writing one
// - protect violation on protected program/erase
// - violation cleared by one, blocks launch
// - busy bit shows controller activity
// - status bits set on error, bit2 zero
// - error status flags read, write-one clear
// - tag counter read-only, decremented before programming
// - all programmed when tag zero, not busy
// - ecc result captured, selected by index
// - partition checks index, load, mode, sizes
// - read error sets status1, uncorrectable status0
// - erase-verify checks words, then completes
// - protection decode from open and disables
// - high range 2 to 16 Kbytes
// - low range 1 to 8 Kbytes
// - protection loaded at reset, software writable
// - partitions in sectors; repeated partition command (not full partition) gives error
//
// Design decision made here: strobed register access.
module fcsp_ctrl
  import fcsp_pkg::*;
#(
  parameter int PARAM_WORDS = 6
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire fcsp_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  output fcsp_arr_req_t arr_req,
  input wire fcsp_arr_rsp_t arr_rsp,
  input wire logic eee_init_fail,
  input wire logic user_mode,
  input wire logic eee_tag_push,
  output logic all_programmed
);
  fcsp_state_t state_q, state_d;
  logic [15:0] param_q [PARAM_WORDS];
  logic [2:0] pix_q;
  logic ccf_q, acc_q, pv_q;
  logic [1:0] st_q;
  logic [1:0] ecc_flags_q;
  logic [7:0] prot_q;
  logic [15:0] tag_q;
  logic [1:0] eix_q;
  logic [22:0] ecc_addr_q;
  logic [15:0] ecc_data_q;
  logic parted_q;
  logic load_active_q;
  logic [15:0] cnt_q;
  logic [22:0] addr_q;
  logic [7:0] rdata_q;
  logic [7:0] step_q;
  logic arr_req_q;

  // bus decode
  wire logic wr = bus_req.wr;
  wire logic [7:0] wd = bus_req.wdata;
  wire logic wr_stat = wr && bus_req.addr == FCSP_OFS_CMD_STATUS;
  wire logic wr_err = wr && bus_req.addr == FCSP_OFS_ERR_STATUS;
  wire logic wr_pix = wr && bus_req.addr == FCSP_OFS_PARAM_INDEX;
  wire logic wr_phi = wr && bus_req.addr == FCSP_OFS_PARAM_HI;
  wire logic wr_plo = wr && bus_req.addr == FCSP_OFS_PARAM_LO;
  wire logic wr_prot = wr && bus_req.addr == FCSP_OFS_PROTECT;
  wire logic wr_eix = wr && bus_req.addr == FCSP_OFS_ECC_INDEX;
  wire logic idle = state_q == FCSP_IDLE;

  // parameter writes only while idle with completion set
  wire logic param_ok = ccf_q && idle && !pv_q && pix_q < 3'(PARAM_WORDS);
  wire logic launch = wr_stat && wd[FCSP_BIT_CCF] && ccf_q && idle && !acc_q && !pv_q;

  // protection decode
  wire logic prot_open = prot_q[FCSP_BIT_OPEN];
  wire logic hdis = prot_q[FCSP_BIT_HDIS];
  wire logic ldis = prot_q[FCSP_BIT_LDIS];
  wire logic [1:0] hs = prot_q[FCSP_BIT_HS +: 2];
  wire logic [1:0] ls = prot_q[FCSP_BIT_LS +: 2];
  wire logic [22:0] high_base = hs == 2'h0 ? FCSP_HIGH_BASE_2K : hs == 2'h1 ? FCSP_HIGH_BASE_4K :
                                hs == 2'h2 ? FCSP_HIGH_BASE_8K : FCSP_HIGH_BASE_16K;
  wire logic [22:0] low_end = ls == 2'h0 ? FCSP_LOW_END_1K : ls == 2'h1 ? FCSP_LOW_END_2K :
                              ls == 2'h2 ? FCSP_LOW_END_4K : FCSP_LOW_END_8K;

  // decode inputs passed in, so a protection write alone re-evaluates the result
  function automatic logic is_protected(input logic [22:0] a, input logic [22:0] hb, input logic [22:0] le,
                                        input logic op, input logic hd, input logic ld);
    logic in_h;
    logic in_l;
    in_h = a >= hb && a <= FCSP_HIGH_END;
    in_l = a >= FCSP_LOW_BASE && a <= le;
    if (op) begin
      is_protected = (!hd && in_h) || (!ld && in_l);
    end else if (hd && ld) begin
      is_protected = 1'b1;
    end else begin
      is_protected = !((!hd && in_h) || (!ld && in_l));
    end
  endfunction : is_protected

  // launch checks
  wire logic [7:0] cmd = param_q[0][15:8];
  wire logic [22:0] cmd_addr = {param_q[0][6:0], param_q[1]};
  wire logic is_pgm_ers = cmd == FCSP_CMD_PROGRAM_PF || cmd == FCSP_CMD_ERASE_PF_SECTOR;
  wire logic is_part = cmd == FCSP_CMD_FULL_PARTITION || cmd == FCSP_CMD_PARTITION;
  wire logic known = is_pgm_ers || is_part || cmd == FCSP_CMD_ERASE_VERIFY_DF || cmd == FCSP_CMD_LOAD_DATA;
  wire logic bad_size = param_q[1] > FCSP_DF_MAX_SECTORS || param_q[2] > FCSP_ER_MAX_SECTORS;
  wire logic part_err = is_part && (pix_q != FCSP_IX_CNT || load_active_q || bad_size ||
                        (cmd == FCSP_CMD_FULL_PARTITION && user_mode) ||
                        (cmd == FCSP_CMD_PARTITION && parted_q));
  wire logic acc_launch = !known || part_err || (cmd == FCSP_CMD_ERASE_VERIFY_DF && pix_q != FCSP_IX_CNT);
  wire logic pv_launch = is_pgm_ers && is_protected(cmd_addr, high_base, low_end, prot_open, hdis, ldis);
  wire logic step_done = step_q == 8'(FCSP_STEP_CYC - 1);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      FCSP_INIT: if (arr_rsp.ack) state_d = FCSP_IDLE;
      FCSP_IDLE: begin
        if (launch) state_d = FCSP_CHECK;
        else if (tag_q != 16'h0) state_d = FCSP_EEE;
      end
      FCSP_CHECK: state_d = (acc_launch || pv_launch || cmd == FCSP_CMD_LOAD_DATA) ? FCSP_IDLE : FCSP_RUN;
      FCSP_RUN: if (arr_rsp.ack && (cnt_q <= 16'h1 || !(cmd == FCSP_CMD_ERASE_VERIFY_DF))) state_d = FCSP_IDLE;
      FCSP_EEE: if (step_done) state_d = FCSP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= FCSP_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  // parameter words, written only when the index selects a real word
  genvar gi;
  for (gi = 0; gi < PARAM_WORDS; gi++) begin : g_param
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        param_q[gi] <= 16'h0;
      end else if (param_ok && pix_q == 3'(gi)) begin
        if (wr_phi) param_q[gi][15:8] <= wd;
        if (wr_plo) param_q[gi][7:0] <= wd;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pix_q <= 3'h0;
      eix_q <= 2'h0;
      load_active_q <= 1'b0;
      parted_q <= 1'b0;
    end else begin
      if (wr_pix && param_ok) pix_q <= wd[2:0];
      if (wr_pix && ccf_q && idle && !pv_q) pix_q <= wd[2:0];
      if (wr_eix) eix_q <= wd[1:0];
      if (state_q == FCSP_CHECK && !acc_launch && !pv_launch) begin
        if (cmd == FCSP_CMD_LOAD_DATA) load_active_q <= 1'b1;
        if (is_pgm_ers) load_active_q <= 1'b0;
        if (is_part) parted_q <= 1'b1;
      end
    end
  end

  // status flags; hardware set wins over software clear
  wire logic rd_err = state_q == FCSP_RUN && arr_rsp.ack && (arr_rsp.sbe || arr_rsp.dbe);
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ccf_q <= 1'b0;
      acc_q <= 1'b0;
      pv_q <= 1'b0;
      st_q <= 2'h0;
    end else begin
      if (launch) ccf_q <= 1'b0;
      else if (state_d == FCSP_IDLE && (state_q == FCSP_INIT || state_q == FCSP_CHECK || state_q == FCSP_RUN))
        ccf_q <= 1'b1;
      if ((state_q == FCSP_CHECK && acc_launch) || (state_q == FCSP_INIT && arr_rsp.ack && eee_init_fail))
        acc_q <= 1'b1;
      else if (wr_stat && wd[FCSP_BIT_ACC]) acc_q <= 1'b0;
      if (state_q == FCSP_CHECK && pv_launch && !acc_launch) pv_q <= 1'b1;
      else if (wr_stat && wd[FCSP_BIT_PV]) pv_q <= 1'b0;
      if (launch) st_q <= 2'h0;
      else if (rd_err || (state_q == FCSP_INIT && arr_rsp.ack && arr_rsp.dbe))
        st_q <= st_q | {1'b1, arr_rsp.dbe};
    end
  end

  // ecc capture: first fault held until cleared
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ecc_flags_q <= 2'h0;
      ecc_addr_q <= 23'h0;
      ecc_data_q <= 16'h0;
    end else begin
      if (arr_rsp.ack && (arr_rsp.sbe || arr_rsp.dbe) && ecc_flags_q == 2'h0) begin
        ecc_addr_q <= arr_req.addr;
        ecc_data_q <= arr_rsp.rdata;
      end
      ecc_flags_q[FCSP_BIT_SFD] <= (arr_rsp.ack && arr_rsp.sbe) ||
        (ecc_flags_q[FCSP_BIT_SFD] && !(wr_err && wd[FCSP_BIT_SFD]));
      ecc_flags_q[FCSP_BIT_DFD] <= (arr_rsp.ack && arr_rsp.dbe) ||
        (ecc_flags_q[FCSP_BIT_DFD] && !(wr_err && wd[FCSP_BIT_DFD]));
    end
  end

  // protection: loaded from flash word at end of reset sequence
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prot_q <= FCSP_RST_PROTECT;
    end else if (state_q == FCSP_INIT && arr_rsp.ack) begin
      prot_q <= arr_rsp.rdata[7:0];
    end else if (wr_prot) begin
      prot_q <= wd;
    end
  end

  // tag counter: decremented before each buffered word is programmed
  // push and take in one cycle cancel, except at 16'hffff, where the push is dropped
  wire logic tag_dec = state_q == FCSP_IDLE && state_d == FCSP_EEE;
  wire logic tag_inc = eee_tag_push && tag_q != 16'hffff;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tag_q <= 16'h0;
      step_q <= 8'h0;
    end else begin
      tag_q <= tag_q + {15'h0, tag_inc} - {15'h0, tag_dec};
      step_q <= state_q == FCSP_EEE && !step_done ? step_q + 8'h1 : 8'h0;
    end
  end

  // array sequencing: address and remaining word count
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_q <= FCSP_PROT_WORD_ADDR;
      cnt_q <= 16'h0;
      arr_req_q <= 1'b1;
    end else begin
      if (state_q == FCSP_CHECK) begin
        addr_q <= cmd_addr;
        cnt_q <= param_q[2];
      end else if (state_q == FCSP_RUN && arr_rsp.ack) begin
        addr_q <= addr_q + 23'h2;
        cnt_q <= cnt_q - 16'h1;
      end
      arr_req_q <= state_d == FCSP_INIT || state_d == FCSP_RUN;
    end
  end

  assign arr_req.req = arr_req_q;
  assign arr_req.addr = addr_q;
  assign arr_req.erase = state_q == FCSP_RUN && cmd == FCSP_CMD_ERASE_PF_SECTOR;
  wire logic busy = !idle;
  assign all_programmed = tag_q == 16'h0 && !busy;

  // read mux, data one cycle after the strobe
  wire logic [7:0] stat_rd = {ccf_q, 1'b0, acc_q, pv_q, busy, 1'b0, st_q};
  wire logic [7:0] ecc_hi = eix_q == 2'h0 ? {1'b0, ecc_addr_q[22:16]} : ecc_data_q[15:8];
  wire logic [7:0] ecc_lo = eix_q == 2'h0 ? 8'h0 : ecc_data_q[7:0];
  wire logic [15:0] pword = pix_q < 3'(PARAM_WORDS) ? param_q[pix_q] : 16'h0;
  logic [7:0] rd_mux;
  always_comb begin
    unique case (bus_req.addr)
      FCSP_OFS_ID: rd_mux = FCSP_ID_VALUE;
      FCSP_OFS_PARAM_INDEX: rd_mux = {5'h0, pix_q};
      FCSP_OFS_ECC_INDEX: rd_mux = {6'h0, eix_q};
      FCSP_OFS_CMD_STATUS: rd_mux = stat_rd;
      FCSP_OFS_ERR_STATUS: rd_mux = {6'h0, ecc_flags_q};
      FCSP_OFS_PROTECT: rd_mux = prot_q;
      FCSP_OFS_PARAM_HI: rd_mux = pword[15:8];
      FCSP_OFS_PARAM_LO: rd_mux = pword[7:0];
      FCSP_OFS_TAG_HI: rd_mux = tag_q[15:8];
      FCSP_OFS_TAG_LO: rd_mux = tag_q[7:0];
      FCSP_OFS_ECC_HI: rd_mux = ecc_hi;
      FCSP_OFS_ECC_LO: rd_mux = ecc_lo;
      default: rd_mux = 8'h0;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 8'h0;
    end else begin
      rdata_q <= bus_req.rd ? rd_mux : 8'h0;
    end
  end
  assign bus_rdata = rdata_q;
endmodule : fcsp_ctrl

// ==== test/fcsp_ctrl_sva.sv ====
// checker: bus answer, status and array port properties of the flash command block
module fcsp_ctrl_chk
  import fcsp_pkg::*;
#(
  parameter int PARAM_WORDS = 6
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire fcsp_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire fcsp_arr_req_t arr_req,
  input wire fcsp_arr_rsp_t arr_rsp,
  input wire logic eee_init_fail,
  input wire logic user_mode,
  input wire logic eee_tag_push,
  input wire logic all_programmed
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire logic rd6 = bus_req.rd && bus_req.addr == FCSP_OFS_CMD_STATUS;
  wire logic wr6 = bus_req.wr && bus_req.addr == FCSP_OFS_CMD_STATUS;
  wire logic rd7 = bus_req.rd && bus_req.addr == FCSP_OFS_ERR_STATUS;
  wire logic wr7 = bus_req.wr && bus_req.addr == FCSP_OFS_ERR_STATUS;
  rdata_idle_a: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data not idle");
  rsvd_zero_a: assert property ($past(rd6) |-> !bus_rdata[2])
    else $error("reserved status bit set");
  init_fetch_a: assert property ($fell(sys_rst) |-> arr_req.req && arr_req.addr == FCSP_PROT_WORD_ADDR)
    else $error("no protection fetch");
  req_hold_a: assert property (arr_req.req && !arr_rsp.ack |=> arr_req.req && $stable(arr_req.addr))
    else $error("array request dropped");
  busy_prog_a: assert property (arr_req.req |-> !all_programmed)
    else $error("programmed while busy");
  busy_read_a: assert property (rd6 && arr_req.req && !$past(arr_rsp.ack) |=>
    bus_rdata[FCSP_BIT_BUSY] && !bus_rdata[FCSP_BIT_CCF]) else $error("busy not shown");
  err_clear_a: assert property (wr7 && bus_req.wdata[1:0] == 2'b11 && !arr_rsp.ack ##1 rd7 && !arr_rsp.ack
    |=> bus_rdata[1:0] == 2'b00) else $error("error status not cleared");
  flag_clear_a: assert property (wr6 && bus_req.wdata == 8'h30 && !arr_rsp.ack ##1 rd6 |=>
    bus_rdata[5:4] == 2'b00) else $error("flags not cleared");
  zero_keep_a: assert property (rd6 ##1 wr6 && bus_req.wdata == 8'h00 && bus_rdata[FCSP_BIT_ACC] ##1 rd6
    |=> bus_rdata[FCSP_BIT_ACC]) else $error("zero write cleared flag");
  launch_block_a: assert property (rd6 ##1 wr6 && bus_req.wdata == 8'h80 && bus_rdata[5:4] != 2'b00 ##1 rd6
    |=> bus_rdata[FCSP_BIT_CCF]) else $error("launch not refused");
  cover property (rd6 && arr_req.req);
  cover property (arr_rsp.ack && arr_rsp.dbe);
  cover property ($rose(all_programmed));
endmodule : fcsp_ctrl_chk

bind fcsp_ctrl fcsp_ctrl_chk #(.PARAM_WORDS(PARAM_WORDS)) u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .arr_req(arr_req), .arr_rsp(arr_rsp), .eee_init_fail(eee_init_fail),
  .user_mode(user_mode), .eee_tag_push(eee_tag_push), .all_programmed(all_programmed));

// ==== test/fcsp_flash_model.sv ====
// flash array stand-in: answers array requests after a prompt or slow delay
module fcsp_flash_model
  import fcsp_pkg::*;
#(
  parameter logic [15:0] PROT_WORD = 16'h00e7
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire fcsp_arr_req_t arr_req,
  input wire logic slow,
  input wire logic bad_ecc,
  input wire logic sgl_ecc,
  output fcsp_arr_rsp_t arr_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_q;
  wire logic [2:0] dly = slow ? 3'h5 : 3'h1;
  wire logic go = arr_req.req && !arr_rsp.ack;
  wire logic [15:0] word = arr_req.addr == FCSP_PROT_WORD_ADDR ? PROT_WORD : 16'hffff;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_q <= 3'h0;
      arr_rsp <= '0;
    end else begin
      arr_rsp.ack <= 1'b0;
      arr_rsp.sbe <= 1'b0;
      arr_rsp.dbe <= 1'b0;
      // data line scrambles outside an answer
      arr_rsp.rdata <= ~arr_rsp.rdata;
      wait_q <= (go && wait_q != dly) ? wait_q + 3'h1 : 3'h0;
      if (go && wait_q == dly) begin
        arr_rsp.ack <= 1'b1;
        arr_rsp.rdata <= word;
        arr_rsp.dbe <= bad_ecc;
        arr_rsp.sbe <= sgl_ecc;
      end
    end
  end
endmodule : fcsp_flash_model

// ==== test/fcsp_tb.sv ====
// bench: register-level tests of the flash command block
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench
  import fcsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  fcsp_bus_req_t bus_req = '0;
  logic [7:0] bus_rdata;
  fcsp_arr_req_t arr_req;
  fcsp_arr_rsp_t arr_rsp;
  logic eee_init_fail = 1'b1;
  logic user_mode = 1'b1;
  logic eee_tag_push = 1'b0;
  logic all_programmed;
  logic slow = 1'b0;
  logic bad_ecc = 1'b0;
  logic sgl_ecc = 1'b0;
  int erases = 0;
  logic twice = 1'b0;
  logic [7:0] v;
  logic [22:0] ad;
  int num_errors = 0;
  int checks = 0;
  int acks = 0;
  int n;
  fcsp_ctrl u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .arr_req(arr_req), .arr_rsp(arr_rsp), .eee_init_fail(eee_init_fail), .user_mode(user_mode),
    .eee_tag_push(eee_tag_push), .all_programmed(all_programmed));
  fcsp_flash_model u_flash (.core_clk(core_clk), .sys_rst(sys_rst), .arr_req(arr_req), .slow(slow),
    .bad_ecc(bad_ecc), .sgl_ecc(sgl_ecc), .arr_rsp(arr_rsp));
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (arr_rsp.ack) acks++;
  always @(posedge core_clk) if (arr_rsp.ack && arr_req.erase === 1'b1) erases++;
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // every bus task starts and ends just after a clock edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req <= '0;
    #1;
    d = bus_rdata;
  endtask : rd
  task automatic chk(input logic [3:0] a, input logic [7:0] e, input string s);
    rd(a, v);
    `CHK(s, e, v)
  endtask : chk
  task automatic wait_done();
    for (int i = 0; i < 200; i++) begin
      rd(FCSP_OFS_CMD_STATUS, v);
      if (v[FCSP_BIT_CCF] === 1'b1) return;
    end
    num_errors++;
    finish_test();
  endtask : wait_done
  task automatic word(input logic [2:0] ix, input logic [15:0] w);
    wr(FCSP_OFS_PARAM_INDEX, {5'h00, ix});
    wr(FCSP_OFS_PARAM_HI, w[15:8]);
    wr(FCSP_OFS_PARAM_LO, w[7:0]);
  endtask : word
  task automatic cmd(input logic [7:0] c, input logic [22:0] a, input logic [15:0] w2, input logic [7:0] e);
    word(FCSP_IX_CMD, {c, 1'b0, a[22:16]});
    word(FCSP_IX_ADDR, a[15:0]);
    word(FCSP_IX_CNT, w2);
    wr(FCSP_OFS_CMD_STATUS, 8'h80);
    if (twice) begin
      word(FCSP_IX_CNT, 16'h0009);
      wr(FCSP_OFS_CMD_STATUS, 8'h80);
    end
    wait_done();
    `CHK("status", e, v)
  endtask : cmd
  task automatic refuse(input logic [7:0] e);
    wr(FCSP_OFS_CMD_STATUS, 8'h80);
    chk(FCSP_OFS_CMD_STATUS, e, "launch refused");
    wr(FCSP_OFS_CMD_STATUS, 8'h00);
    chk(FCSP_OFS_CMD_STATUS, e, "zero write");
    wr(FCSP_OFS_CMD_STATUS, 8'h30);
    chk(FCSP_OFS_CMD_STATUS, {e[7:6], 2'b00, e[3:0]}, "one write");
  endtask : refuse
  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1;
    wait_done();
    `CHK("init status", 8'ha0, v)
    refuse(8'ha0);
    eee_init_fail <= 1'b0;
    chk(FCSP_OFS_PROTECT, 8'he7, "prot load");
    chk(FCSP_OFS_ID, FCSP_ID_VALUE, "id");
    chk(4'h2, 8'h00, "unmapped");
    wr(FCSP_OFS_TAG_LO, 8'hff);
    chk(FCSP_OFS_TAG_LO, 8'h00, "tag ro");
    cmd(8'h55, 23'h0, 16'h0002, 8'ha0);
    refuse(8'ha0);
    $display("test reset and illegal done");
    n = acks;
    cmd(FCSP_CMD_ERASE_VERIFY_DF, 23'h10_0000, 16'h0003, 8'h80);
    `CHK("words", n + 3, acks)
    slow <= 1'b1;
    twice = 1'b1;
    n = acks;
    cmd(FCSP_CMD_ERASE_VERIFY_DF, 23'h10_0000, 16'h0003, 8'h80);
    `CHK("words slow", n + 3, acks)
    twice = 1'b0;
    bad_ecc <= 1'b1;
    cmd(FCSP_CMD_ERASE_VERIFY_DF, 23'h10_0000, 16'h0002, 8'h83);
    bad_ecc <= 1'b0;
    wr(FCSP_OFS_ECC_INDEX, 8'h00);
    chk(FCSP_OFS_ECC_HI, 8'h10, "ecc addr");
    chk(FCSP_OFS_ERR_STATUS, 8'h02, "double fault");
    wr(FCSP_OFS_ERR_STATUS, 8'h03);
    chk(FCSP_OFS_ERR_STATUS, 8'h00, "fault clear");
    sgl_ecc <= 1'b1;
    cmd(FCSP_CMD_ERASE_VERIFY_DF, 23'h10_0000, 16'h0001, 8'h82);
    sgl_ecc <= 1'b0;
    chk(FCSP_OFS_ERR_STATUS, 8'h01, "single fault");
    wr(FCSP_OFS_ERR_STATUS, 8'h01);
    slow <= 1'b0;
    $display("test erase verify done");
    for (int i = 0; i < 4; i++) begin
      wr(FCSP_OFS_PROTECT, {3'b100, i[1:0], 3'b100});
      ad = FCSP_HIGH_END - (23'h800 << i) + 23'h1;
      cmd(FCSP_CMD_ERASE_PF_SECTOR, ad, 16'h0, 8'h90);
      refuse(8'h90);
      cmd(FCSP_CMD_ERASE_PF_SECTOR, ad - 23'h2, 16'h0, 8'h80);
      wr(FCSP_OFS_PROTECT, {3'b101, 2'b00, 1'b0, i[1:0]});
      ad = FCSP_LOW_BASE + (23'h400 << i) - 23'h1;
      cmd(FCSP_CMD_ERASE_PF_SECTOR, ad - 23'h1, 16'h0, 8'h90);
      refuse(8'h90);
      cmd(FCSP_CMD_ERASE_PF_SECTOR, ad + 23'h1, 16'h0, 8'h80);
    end
    wr(FCSP_OFS_PROTECT, 8'h04);
    cmd(FCSP_CMD_ERASE_PF_SECTOR, 23'h7f_f800, 16'h0, 8'h80);
    cmd(FCSP_CMD_ERASE_PF_SECTOR, 23'h40_0000, 16'h0, 8'h90);
    refuse(8'h90);
    wr(FCSP_OFS_PROTECT, 8'h24);
    cmd(FCSP_CMD_PROGRAM_PF, 23'h7f_f800, 16'h0, 8'h90);
    refuse(8'h90);
    wr(FCSP_OFS_PROTECT, 8'he7);
    `CHK("erases", 9, erases)
    $display("test protection done");
    cmd(FCSP_CMD_FULL_PARTITION, 23'h10, 16'h0004, 8'ha0);
    refuse(8'ha0);
    user_mode <= 1'b0;
    cmd(FCSP_CMD_PARTITION, 23'h81, 16'h0004, 8'ha0);
    refuse(8'ha0);
    cmd(FCSP_CMD_PARTITION, 23'h10, 16'h0004, 8'h80);
    cmd(FCSP_CMD_PARTITION, 23'h10, 16'h0004, 8'ha0);
    refuse(8'ha0);
    cmd(FCSP_CMD_LOAD_DATA, 23'h10_0000, 16'h0001, 8'h80);
    cmd(FCSP_CMD_FULL_PARTITION, 23'h10, 16'h0004, 8'ha0);
    refuse(8'ha0);
    $display("test partition done");
    @(posedge core_clk);
    eee_tag_push <= 1'b1;
    repeat (3) @(posedge core_clk);
    eee_tag_push <= 1'b0;
    #1;
    `CHK("pending", 1'b0, all_programmed)
    rd(FCSP_OFS_CMD_STATUS, v);
    `CHK("busy", 1'b1, v[FCSP_BIT_BUSY])
    n = 0;
    while (n < 100 && all_programmed !== 1'b1) begin
      @(posedge core_clk);
      n++;
    end
    #1;
    `CHK("drained", 1'b1, all_programmed)
    `CHK("drain time", 1'b1, n > 2 * FCSP_STEP_CYC)
    chk(FCSP_OFS_TAG_LO, 8'h00, "tag lo");
    chk(FCSP_OFS_CMD_STATUS, 8'h80, "idle");
    $display("test tag counter done");
    wr(FCSP_OFS_PROTECT, 8'h00);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1;
    wait_done();
    `CHK("reinit status", 8'h80, v)
    chk(FCSP_OFS_PROTECT, 8'he7, "prot reload");
    $display("test second reset done");
    finish_test();
  end
endmodule : testbench
